//--- bdc_ch_if.sv
// Interface carrying one channel's staged bytes and commit strobe.
`timescale 1ns/100ps
interface bdc_ch_if;
	logic [7:0] high_byte;
	logic [7:0] mid_byte;
	logic [1:0] low_bits;
	logic touched;
	logic commit;
	modport regs (output high_byte, output mid_byte, output low_bits, output touched,
		input commit);
	modport shadow (input high_byte, input mid_byte, input low_bits, input touched,
		output commit);
endinterface

//--- bdc_ch_shadow.sv
// Active on-time copy of one channel, updated as a whole.
`timescale 1ns/100ps
module bdc_ch_shadow (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic frame_end,
	bdc_ch_if.shadow ch,
	output logic [bdc_pkg::ONT_W-1:0] active_value
);
	bdc_pkg::bdc_commit_e state_q, state_d;
	logic [bdc_pkg::ONT_W-1:0] value_q, value_d;

	// A commit waits for the period boundary so no pulse sees a half-written value.
	always_comb begin
		state_d = state_q;
		value_d = value_q;
		case (state_q)
			bdc_pkg::BDC_IDLE: begin
				if (ch.touched) begin
					state_d = bdc_pkg::BDC_PEND;
				end
			end
			bdc_pkg::BDC_PEND: begin
				if (frame_end) begin
					state_d = bdc_pkg::BDC_COMMIT;
				end
			end
			bdc_pkg::BDC_COMMIT: begin
				value_d = {ch.high_byte, ch.mid_byte, ch.low_bits}; // [R10]
				// A write in this cycle leaves touched set, so idle re-arms on the next edge.
				state_d = bdc_pkg::BDC_IDLE;
			end
			default: begin
				state_d = bdc_pkg::BDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= bdc_pkg::BDC_IDLE;
			value_q <= {bdc_pkg::ONT_BYTE_RST, bdc_pkg::ONT_BYTE_RST, bdc_pkg::LOW_BITS_RST[1:0]};
		end else begin
			state_q <= state_d;
			value_q <= value_d;
		end
	end

	assign ch.commit = (state_q == bdc_pkg::BDC_COMMIT);
	assign active_value = value_q;
endmodule

//--- bdc_host.sv
// Parallel-bus host model issuing register writes and reads.
`timescale 1ns/100ps
module bdc_host (
	input wire logic mclk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// The strobe stays up after a write so writes can run back to back; a read lowers it.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		d = reg_rdata;
	endtask
endmodule

//--- bdc_pkg.sv
// Shared constants and types for the backlight dimming register bank.
package bdc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int ONT_W = 18;
	localparam int NCH = 2;
	localparam int NFLAG = 4;

	localparam logic [7:0] ADDR_CURRENT = 8'h02;
	localparam logic [7:0] ADDR_MODE = 8'h03;
	localparam logic [7:0] ADDR_CH1_HIGH = 8'h04;
	localparam logic [7:0] ADDR_CH1_MID = 8'h05;
	localparam logic [7:0] ADDR_CH2_HIGH = 8'h06;
	localparam logic [7:0] ADDR_CH2_MID = 8'h07;
	localparam logic [7:0] ADDR_LOW_BITS = 8'h0c;

	localparam logic [3:0] CURRENT_RST = 4'hb;
	localparam logic [7:0] CURRENT_BASE_MA = 8'h2d;
	localparam logic [7:0] CURRENT_STEP_MA = 8'h05;
	localparam logic [7:0] ONT_BYTE_RST = 8'hff;
	localparam logic [7:0] LOW_BITS_RST = 8'hff;

	localparam int MODE_FLAG_LSB = 4;
	localparam int MODE_EXT_BIT = 3;
	localparam int MODE_HYB_BIT = 2;
	localparam int MODE_THR_LSB = 0;
	localparam logic EXT_RST = 1'b1;
	localparam logic HYB_RST = 1'b0;
	localparam logic [1:0] THR_RST = 2'h0;

	localparam int ONT_HIGH_LSB = 10;
	localparam int ONT_MID_LSB = 2;
	localparam int ONT_UNIT_NS = 50;
	localparam int CLK_PERIOD_NS = 100;

	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	typedef enum logic [2:0] {
		BDC_IDLE = 3'b001,
		BDC_PEND = 3'b010,
		BDC_COMMIT = 3'b100
	} bdc_commit_e;
endpackage

//--- bdc_pwm_gen.sv
// Pulse generator for one channel, counting on-time in 50 ns units.
`timescale 1ns/100ps
module bdc_pwm_gen (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [bdc_pkg::ONT_W-1:0] on_time,
	output logic frame_end,
	output logic pwm_on
);
	localparam logic [bdc_pkg::ONT_W-1:0] UNITS_PER_CLK =
		bdc_pkg::ONT_W'(bdc_pkg::CLK_PERIOD_NS / bdc_pkg::ONT_UNIT_NS);
	logic [bdc_pkg::ONT_W-1:0] cnt_q, cnt_d;

	// At 100 ns per clock the count steps two units; the last unit is lost. [R06]
	always_comb begin
		if (cnt_q >= {bdc_pkg::ONT_W{1'b1}} - UNITS_PER_CLK) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + UNITS_PER_CLK;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign frame_end = (cnt_d == '0);
	assign pwm_on = (cnt_q < on_time); // [R06]
endmodule

//--- bdc_regs.sv
// Backlight dimming register bank with coherent on-time update.
// Functional notes
// [R01] Current code linear: 45mA plus 5mA steps.
// [R02] Mode bits 7:4 show low-dim flags ch4..1.
// [R03] Mode bit 3 selects pin or register dimming.
// [R04] Mode bit 2 enables hybrid dimming, resets 0.
// [R05] Bits 1:0 pick crossover, reset 00 (6.25%).
// [R06] Each channel holds 18-bit on-time, 50ns units.
// [R07] High byte bits 17:10, middle byte 9:2.
// [R08] Ch1 at 04/05, ch2 at 06/07, reset ones.
// [R09] Shared register 0x0C holds two low bits each.
// [R10] Multi-byte on-time updates apply as one.
`timescale 1ns/100ps
module bdc_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic brightness_pin,
	input wire logic [3:0] low_dim_in,
	output logic [3:0] led_current_code,
	output logic [7:0] led_current_ma,
	output logic external_brightness_select,
	output logic hybrid_dim_enable,
	output logic [1:0] hybrid_crossover_select,
	output logic [17:0] ch1_on_time_value,
	output logic [17:0] ch2_on_time_value,
	output logic [1:0] dim_out
);
	logic [3:0] cur_q, cur_d;
	logic ext_q, ext_d, hyb_q, hyb_d;
	logic [1:0] thr_q, thr_d;
	logic [7:0] high_q [bdc_pkg::NCH], high_d [bdc_pkg::NCH];
	logic [7:0] mid_q [bdc_pkg::NCH], mid_d [bdc_pkg::NCH];
	logic [7:0] lsb_q, lsb_d;
	logic [bdc_pkg::NCH-1:0] touch_q, touch_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] ma_q, ma_d;
	logic [1:0] dim_q, dim_d;
	logic [3:0] pin_s1_q, pin_s2_q;
	logic [bdc_pkg::NCH-1:0] commit, frame_end, pwm_on;
	logic [17:0] act [bdc_pkg::NCH];

	function automatic logic [7:0] code_to_ma(input logic [3:0] code);
		code_to_ma = bdc_pkg::CURRENT_BASE_MA + 8'(code * bdc_pkg::CURRENT_STEP_MA); // [R01]
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = reg_wr && (a == b);
	endfunction

	bdc_ch_if chif [bdc_pkg::NCH] ();

	for (genvar c = 0; c < bdc_pkg::NCH; c++) begin : g_ch
		assign chif[c].high_byte = high_q[c];
		assign chif[c].mid_byte = mid_q[c];
		assign chif[c].low_bits = lsb_q[2*c+1 -: 2]; // [R09]
		assign chif[c].touched = touch_q[c];
		assign commit[c] = chif[c].commit;
		bdc_ch_shadow u_shadow (
			.mclk(mclk),
			.rst_n(rst_n),
			.frame_end(frame_end[c]),
			.ch(chif[c]),
			.active_value(act[c])
		);
		bdc_pwm_gen u_pwm (
			.mclk(mclk),
			.rst_n(rst_n),
			.on_time(act[c]),
			.frame_end(frame_end[c]),
			.pwm_on(pwm_on[c])
		);
	end

	// Status pins and the brightness pin come from outside; synchronise all.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= low_dim_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	logic pin_b1_q, pin_b2_q;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_b1_q <= 1'b0;
			pin_b2_q <= 1'b0;
		end else begin
			pin_b1_q <= brightness_pin;
			pin_b2_q <= pin_b1_q;
		end
	end

	always_comb begin
		cur_d = cur_q;
		ext_d = ext_q;
		hyb_d = hyb_q;
		thr_d = thr_q;
		lsb_d = lsb_q;
		rdata_d = rdata_q;
		for (int c = 0; c < bdc_pkg::NCH; c++) begin
			high_d[c] = high_q[c];
			mid_d[c] = mid_q[c];
			// A write in the commit cycle keeps the channel pending.
			touch_d[c] = touch_q[c] & ~commit[c];
		end
		if (hit(reg_addr, bdc_pkg::ADDR_CURRENT)) begin
			cur_d = reg_wdata[3:0]; // [R01]
		end
		if (hit(reg_addr, bdc_pkg::ADDR_MODE)) begin
			ext_d = reg_wdata[bdc_pkg::MODE_EXT_BIT]; // [R03]
			hyb_d = reg_wdata[bdc_pkg::MODE_HYB_BIT]; // [R04]
			thr_d = reg_wdata[bdc_pkg::MODE_THR_LSB +: 2]; // [R05]
		end
		if (hit(reg_addr, bdc_pkg::ADDR_CH1_HIGH)) begin
			high_d[0] = reg_wdata; // [R08]
			touch_d[0] = 1'b1;
		end
		if (hit(reg_addr, bdc_pkg::ADDR_CH1_MID)) begin
			mid_d[0] = reg_wdata; // [R08]
			touch_d[0] = 1'b1;
		end
		if (hit(reg_addr, bdc_pkg::ADDR_CH2_HIGH)) begin
			high_d[1] = reg_wdata; // [R08]
			touch_d[1] = 1'b1;
		end
		if (hit(reg_addr, bdc_pkg::ADDR_CH2_MID)) begin
			mid_d[1] = reg_wdata; // [R08]
			touch_d[1] = 1'b1;
		end
		if (hit(reg_addr, bdc_pkg::ADDR_LOW_BITS)) begin
			lsb_d = reg_wdata; // [R09]
			touch_d = '1;
		end
		if (reg_rd) begin
			case (reg_addr)
				bdc_pkg::ADDR_CURRENT: rdata_d = {4'h0, cur_q};
				bdc_pkg::ADDR_MODE: rdata_d = {pin_s2_q, ext_q, hyb_q, thr_q}; // [R02]
				bdc_pkg::ADDR_CH1_HIGH: rdata_d = high_q[0];
				bdc_pkg::ADDR_CH1_MID: rdata_d = mid_q[0];
				bdc_pkg::ADDR_CH2_HIGH: rdata_d = high_q[1];
				bdc_pkg::ADDR_CH2_MID: rdata_d = mid_q[1];
				bdc_pkg::ADDR_LOW_BITS: rdata_d = lsb_q;
				default: rdata_d = bdc_pkg::READ_UNMAPPED;
			endcase
		end
		ma_d = code_to_ma(cur_q);
		// Pin dimming passes the synchronised pin; otherwise the register PWM.
		for (int c = 0; c < bdc_pkg::NCH; c++) begin
			dim_d[c] = ext_q ? pin_b2_q : pwm_on[c]; // [R03]
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cur_q <= bdc_pkg::CURRENT_RST; // [R01]
			ext_q <= bdc_pkg::EXT_RST; // [R03]
			hyb_q <= bdc_pkg::HYB_RST; // [R04]
			thr_q <= bdc_pkg::THR_RST; // [R05]
			lsb_q <= bdc_pkg::LOW_BITS_RST;
			touch_q <= '0;
			rdata_q <= bdc_pkg::READ_UNMAPPED;
			ma_q <= bdc_pkg::CURRENT_BASE_MA;
			dim_q <= '0;
			for (int c = 0; c < bdc_pkg::NCH; c++) begin
				high_q[c] <= bdc_pkg::ONT_BYTE_RST; // [R08]
				mid_q[c] <= bdc_pkg::ONT_BYTE_RST;
			end
		end else begin
			cur_q <= cur_d;
			ext_q <= ext_d;
			hyb_q <= hyb_d;
			thr_q <= thr_d;
			lsb_q <= lsb_d;
			touch_q <= touch_d;
			rdata_q <= rdata_d;
			ma_q <= ma_d;
			dim_q <= dim_d;
			for (int c = 0; c < bdc_pkg::NCH; c++) begin
				high_q[c] <= high_d[c];
				mid_q[c] <= mid_d[c];
			end
		end
	end

	assign led_current_code = cur_q;
	assign led_current_ma = ma_q;
	assign external_brightness_select = ext_q;
	assign hybrid_dim_enable = hyb_q;
	assign hybrid_crossover_select = thr_q;
	assign ch1_on_time_value = act[0]; // [R07]
	assign ch2_on_time_value = act[1]; // [R07]
	assign reg_rdata = rdata_q;
	assign dim_out = dim_q;
endmodule

//--- bdc_regs_assertions.sv
// Port-level checks for the dimming register bank.
`timescale 1ns/100ps
module bdc_regs_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic brightness_pin,
	input wire logic [3:0] low_dim_in,
	input wire logic [3:0] led_current_code,
	input wire logic [7:0] led_current_ma,
	input wire logic external_brightness_select,
	input wire logic hybrid_dim_enable,
	input wire logic [1:0] hybrid_crossover_select,
	input wire logic [17:0] ch1_on_time_value,
	input wire logic [1:0] dim_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic mode_wr;
	assign mode_wr = reg_wr && reg_addr == bdc_pkg::ADDR_MODE;
	property p_rst;
		$rose(rst_n) |-> led_current_code == bdc_pkg::CURRENT_RST && external_brightness_select
			&& !hybrid_dim_enable && hybrid_crossover_select == 2'h0
			&& ch1_on_time_value == 18'h3ffff;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_ma;
		$past(rst_n) |-> led_current_ma == bdc_pkg::CURRENT_BASE_MA
			+ bdc_pkg::CURRENT_STEP_MA * {4'h0, $past(led_current_code)};
	endproperty
	a_ma: assert property (p_ma) else $error("current decode wrong");
	property p_ext;
		mode_wr |=> external_brightness_select == $past(reg_wdata[3]);
	endproperty
	a_ext: assert property (p_ext) else $error("source select not written");
	property p_hyb;
		mode_wr |=> hybrid_dim_enable == $past(reg_wdata[2]);
	endproperty
	a_hyb: assert property (p_hyb) else $error("hybrid enable not written");
	property p_thr;
		mode_wr |=> hybrid_crossover_select == $past(reg_wdata[1:0]);
	endproperty
	a_thr: assert property (p_thr) else $error("crossover not written");
	property p_flag;
		$stable(low_dim_in) [*4] ##0 (reg_rd && reg_addr == bdc_pkg::ADDR_MODE) |=>
			reg_rdata == {$past(low_dim_in), $past(external_brightness_select),
			$past(hybrid_dim_enable), $past(hybrid_crossover_select)};
	endproperty
	a_flag: assert property (p_flag) else $error("mode readback wrong");
	property p_pin;
		(external_brightness_select && $stable(brightness_pin)) [*5] |->
			dim_out == {2{brightness_pin}};
	endproperty
	a_pin: assert property (p_pin) else $error("pin dimming not followed");
	property p_back;
		reg_wr && reg_addr inside {[8'h04:8'h07], 8'h0c} ##1
			reg_rd && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_back: assert property (p_back) else $error("on-time byte readback wrong");
endmodule
bind bdc_regs bdc_regs_chk chk_u (
	.mclk(mclk),
	.rst_n(rst_n),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.brightness_pin(brightness_pin),
	.low_dim_in(low_dim_in),
	.led_current_code(led_current_code),
	.led_current_ma(led_current_ma),
	.external_brightness_select(external_brightness_select),
	.hybrid_dim_enable(hybrid_dim_enable),
	.hybrid_crossover_select(hybrid_crossover_select),
	.ch1_on_time_value(ch1_on_time_value),
	.dim_out(dim_out)
);

//--- tb_backlight_dimming_control_regs.sv
// Self-checking testbench for the dimming register bank.
`timescale 1ns/100ps
module tb_backlight_dimming_control_regs;
	logic mclk, rst_n, reg_wr, reg_rd, brightness_pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, led_current_ma, d;
	logic [3:0] low_dim_in, led_current_code;
	logic external_brightness_select, hybrid_dim_enable;
	logic [1:0] hybrid_crossover_select, dim_out;
	logic [17:0] ch1_on_time_value, ch2_on_time_value;
	logic [7:0] ra[8] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0c, 8'h20};
	logic [7:0] rv[8] = '{8'h0b, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
	logic [7:0] wv[5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9c};
	int n_mismatch, n_compared;
	bdc_host host_u (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	bdc_regs dut_u (
		.mclk(mclk),
		.rst_n(rst_n),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.brightness_pin(brightness_pin),
		.low_dim_in(low_dim_in),
		.led_current_code(led_current_code),
		.led_current_ma(led_current_ma),
		.external_brightness_select(external_brightness_select),
		.hybrid_dim_enable(hybrid_dim_enable),
		.hybrid_crossover_select(hybrid_crossover_select),
		.ch1_on_time_value(ch1_on_time_value),
		.ch2_on_time_value(ch2_on_time_value),
		.dim_out(dim_out)
	);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		final_report;
	end
	initial begin
		n_mismatch = 0;
		n_compared = 0;
		rst_n = 1'b0;
		brightness_pin = 1'b0;
		low_dim_in = 4'h0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			host_u.rd(ra[i], d);
			chk(d, rv[i]);
		end
		chk(ch1_on_time_value, 18'h3ffff);
		chk(ch2_on_time_value, 18'h3ffff);
		chk(led_current_ma, 8'd100);
		for (int i = 0; i < 16; i++) begin
			host_u.wr(bdc_pkg::ADDR_CURRENT, i[7:0]);
			host_u.rd(bdc_pkg::ADDR_CURRENT, d);
			chk(d, i[7:0]);
			chk(led_current_code, i[3:0]);
			chk(led_current_ma, 8'd45 + 8'd5 * i[7:0]);
		end
		low_dim_in <= 4'ha;
		repeat (4) @(posedge mclk);
		// Read-only flag bits are written as 1101, not the 1010 on low_dim_in, to show they are ignored.
		for (int i = 0; i < 4; i++) begin
			host_u.wr(bdc_pkg::ADDR_MODE, {6'h35, i[1:0]});
			host_u.rd(bdc_pkg::ADDR_MODE, d);
			chk(d, {6'h29, i[1:0]});
			chk(hybrid_crossover_select, i[1:0]);
			// Register dimming with the all-ones reset on-time keeps every pulse on.
			chk(dim_out, 2'h3);
		end
		for (int i = 0; i < 5; i++) begin
			host_u.wr(ra[i + 2], wv[i]);
			host_u.rd(ra[i + 2], d);
			chk(d, wv[i]);
		end
		// No period boundary has passed, so the applied value must not move yet.
		chk(ch1_on_time_value, 18'h3ffff);
		chk(ch2_on_time_value, 18'h3ffff);
		host_u.wr(bdc_pkg::ADDR_MODE, 8'h08);
		host_u.rd(bdc_pkg::ADDR_MODE, d);
		chk(d, 8'ha8);
		chk(external_brightness_select, 1'b1);
		for (int i = 1; i >= 0; i--) begin
			brightness_pin <= i[0];
			repeat (6) @(posedge mclk);
			chk(dim_out, {2{i[0]}});
		end
		// A reset in mid-run must bring the written registers back to their defaults.
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		host_u.rd(bdc_pkg::ADDR_CURRENT, d);
		chk(d, 8'h0b);
		host_u.rd(bdc_pkg::ADDR_CH1_HIGH, d);
		chk(d, 8'hff);
		final_report;
	end
endmodule
